// ### jtag_port_defines.vh
// Constants for the serial test and programming port.
`ifndef JTAG_PORT_DEFINES_VH
`define JTAG_PORT_DEFINES_VH
// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define IR_LEN        8
`define IR_EXTEST     8'h00
`define IR_PLD_ADDR   8'h01
`define IR_PLD_DATA   8'h02
`define IR_BULK_ERASE 8'h03
`define IR_PLD_PROG   8'h07
`define IR_PROG_SEC   8'h09
`define IR_PROG_EN    8'h15
`define IR_IDCODE     8'h16
`define IR_HIGHZ      8'h18
`define IR_USER_SIGNATURE_READ 8'h1a
`define IR_USER_SIGNATURE_PROG 8'h1b
`define IR_SAMPLE     8'h1c
`define IR_PROG_DIS   8'h1e
`define IR_CFG_VERIFY 8'h28
`define IR_CFG_ERASE  8'h29
`define IR_CFG_ADDR   8'h2b
`define IR_CFG_SHIFT  8'h2d
`define IR_CFG_PROG   8'h2e
`define IR_BYPASS     8'hff
// ----------------------------------------
// Data register lengths and values
// ----------------------------------------
`define DR_MAX        123
`define LEN_BYPASS    7'd1
`define LEN_BSR       7'd4
`define LEN_CFG_ADDR  7'd12
`define LEN_ID        7'd32
`define LEN_CFG_DATA  7'd56
`define LEN_PLD_ADDR  7'd109
`define LEN_PLD_DATA  7'd123
`define CFG_ROWS      4
`define IDLOAD_COUNT  3'd4
`define USER_SIGNATURE_RESET 32'hffffffff
// Identification value is arbitrary and names no maker or part.
`define IDCODE_VALUE  32'h0a5a5001
`define ERASED_BIT    1'b1
// ----------------------------------------
// Pin counts
// ----------------------------------------
`define N_PINS        14
`define N_GATES       2
`define N_INS         4
// ----------------------------------------
// TAP states, one-hot
// ----------------------------------------
`define ST_TLR   16'h0001
`define ST_RTI   16'h0002
`define ST_SELDR 16'h0004
`define ST_CAPDR 16'h0008
`define ST_SHDR  16'h0010
`define ST_EX1DR 16'h0020
`define ST_PSDR  16'h0040
`define ST_EX2DR 16'h0080
`define ST_UPDR  16'h0100
`define ST_SELIR 16'h0200
`define ST_CAPIR 16'h0400
`define ST_SHIR  16'h0800
`define ST_EX1IR 16'h1000
`define ST_PSIR  16'h2000
`define ST_EX2IR 16'h4000
`define ST_UPIR  16'h8000
`endif

// ### tap_state_machine.v
// Sixteen-state test access port controller.
`timescale 1ns/1ps
`include "jtag_port_defines.vh"
module tap_state_machine (
  input  wire        ref_clk, // System clock.
  input  wire        rst,     // Asynchronous reset, active high.
  input  wire        step,    // One-cycle pulse on a rising test clock edge.
  input  wire        tms,     // Synchronised mode select.
  output reg  [15:0] state_q  // Current one-hot state.
);
  localparam [15:0] TLR = `ST_TLR, RTI = `ST_RTI, SELDR = `ST_SELDR, CAPDR = `ST_CAPDR;
  localparam [15:0] SHDR = `ST_SHDR, EX1DR = `ST_EX1DR, PSDR = `ST_PSDR, EX2DR = `ST_EX2DR;
  localparam [15:0] UPDR = `ST_UPDR, SELIR = `ST_SELIR, CAPIR = `ST_CAPIR, SHIR = `ST_SHIR;
  localparam [15:0] EX1IR = `ST_EX1IR, PSIR = `ST_PSIR, EX2IR = `ST_EX2IR, UPIR = `ST_UPIR;
  reg [15:0] state_d;
  always @* begin
    case (state_q)
      TLR:     state_d = tms ? TLR : RTI;
      RTI:     state_d = tms ? SELDR : RTI;
      SELDR:   state_d = tms ? SELIR : CAPDR;
      CAPDR:   state_d = tms ? EX1DR : SHDR;
      SHDR:    state_d = tms ? EX1DR : SHDR;
      EX1DR:   state_d = tms ? UPDR : PSDR;
      PSDR:    state_d = tms ? EX2DR : PSDR;
      EX2DR:   state_d = tms ? UPDR : SHDR;
      UPDR:    state_d = tms ? SELDR : RTI;
      SELIR:   state_d = tms ? TLR : CAPIR;
      CAPIR:   state_d = tms ? EX1IR : SHIR;
      SHIR:    state_d = tms ? EX1IR : SHIR;
      EX1IR:   state_d = tms ? UPIR : PSIR;
      PSIR:    state_d = tms ? EX2IR : PSIR;
      EX2IR:   state_d = tms ? UPIR : SHIR;
      UPIR:    state_d = tms ? SELDR : RTI;
      default: state_d = TLR;
    endcase
  end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= TLR;
    end else if (step) begin
      state_q <= state_d;
    end
  end
endmodule

// ### jtag_port_alt_data_input.v
// Test and programming port with alternate data input selection.
`timescale 1ns/1ps
`include "jtag_port_defines.vh"
// Behaviour
// - Select pin low or four ID loads pick alternate
// - Alternate input picked by ID loads held until Test-Logic-Reset
// - Select pin pulled up, defaults to normal
// - Reset and Capture-IR load ID instruction
// - Programming-supply-only: outputs off, inputs ignored
// - 32-bit user signature in non-volatile storage
// - Security fuse blocks configuration readout
// - Fuse cleared only by bulk erase or reset
// - Instruction selects data register and operation
// - Bypass and boundary-scan paths provided
// - Instruction 8 bits, bypass 1 bit
// - Logic data 123, address 109 bits
// - Config address 12, config data 56 bits
module jtag_port_alt_data_input (
  input  wire                  ref_clk,                // System clock, 40 MHz.
  input  wire                  rst,                    // Asynchronous reset, active high.
  input  wire                  test_clk,               // Test clock pin.
  input  wire                  test_mode_sel,          // Test mode select pin.
  input  wire                  test_data_in,           // Normal test data input pin.
  input  wire                  alternate_data_in,      // Alternate test data input pin.
  input  wire                  data_input_select_pin,  // High selects normal input.
  input  wire                  programming_supply_pin, // High when only the programming supply is up.
  input  wire [`N_PINS-1:0]    func_out,               // Core digital output values.
  input  wire [`N_PINS-1:0]    func_out_oe,            // Core digital output enables.
  input  wire [`N_GATES-1:0]   gate_drive_req,         // Core gate-driver requests.
  input  wire [`N_INS-1:0]     func_in,                // Digital input pins.
  output wire                  test_data_out,          // Test data output.
  output wire                  test_data_out_oe,       // Test data output enable.
  output wire                  select_pullup_en,       // Pull-up enable for the select pad.
  output wire [`N_PINS-1:0]    pin_out,                // Digital output pin values.
  output wire [`N_PINS-1:0]    pin_oe,                 // Digital output pin enables.
  output wire [`N_GATES-1:0]   gate_driver_output,     // Gate-driver outputs.
  output wire [`N_INS-1:0]     func_in_gated,          // Inputs passed to the core.
  output wire                  alt_input_active,       // Alternate data input in use.
  output wire                  security_fuse           // Security fuse state.
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [5:0] raw_in = {programming_supply_pin, data_input_select_pin, alternate_data_in,
                       test_data_in, test_mode_sel, test_clk};
  reg  [5:0] sync1_q;
  reg  [5:0] sync2_q;
  reg        tck_prev_q;
  genvar     g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sync1_q[g] <= (g == 4) ? 1'b1 : 1'b0;
          sync2_q[g] <= (g == 4) ? 1'b1 : 1'b0;
        end else begin
          sync1_q[g] <= raw_in[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= sync2_q[0];
    end
  end
  wire tck_rise  = sync2_q[0] & ~tck_prev_q;
  wire tck_fall  = ~sync2_q[0] & tck_prev_q;
  wire tms_s     = sync2_q[1];
  wire prog_only = sync2_q[5];
  // The pad pull-up is always on so a floating select pin reads as normal input.
  assign select_pullup_en = 1'b1;
  // ----------------------------------------
  // Controller
  // ----------------------------------------
  wire [15:0] st;
  tap_state_machine u_tap (
    .ref_clk (ref_clk),
    .rst     (rst),
    .step    (tck_rise),
    .tms     (tms_s),
    .state_q (st)
  );
  // ----------------------------------------
  // Data input selection
  // ----------------------------------------
  reg [2:0] id_cnt_q;
  reg       alt_lock_q;
  wire      use_alt = ~sync2_q[4] | alt_lock_q;
  wire      din     = use_alt ? sync2_q[3] : sync2_q[2];
  assign alt_input_active = use_alt;
  // ----------------------------------------
  // Instruction and data registers
  // ----------------------------------------
  reg  [`IR_LEN-1:0] ir_q;
  reg  [`IR_LEN-1:0] ir_sh_q;
  reg  [`DR_MAX-1:0] dr_q;
  reg  [`DR_MAX-1:0] dr_cap;
  reg  [6:0]         dr_len;
  wire [`DR_MAX:0]   dr_pad = {1'b0, dr_q};
  wire [`DR_MAX-1:0] dr_shift;
  reg  [108:0]       pld_addr_q;
  reg  [122:0]       pld_data_q;
  reg  [122:0]       pld_nv_q;
  reg  [11:0]        cfg_addr_q;
  reg  [55:0]        cfg_data_q;
  reg  [55:0]        cfg_nv_q [0:`CFG_ROWS-1];
  reg  [31:0]        user_signature_q;
  reg                fuse_q;
  reg                prog_en_q;
  reg                tdo_q;
  reg                tdo_oe_q;
  wire [55:0]        cfg_row = cfg_nv_q[cfg_addr_q[1:0]];
  integer            k;
  // Serial path: the bit at the selected length takes the input, lower bits move toward bit 0.
  generate
    for (g = 0; g < `DR_MAX; g = g + 1) begin : g_shift
      localparam [6:0] POS = g + 1;
      assign dr_shift[g] = (POS == dr_len) ? din : ((POS < dr_len) ? dr_pad[g + 1] : 1'b0);
    end
  endgenerate
  // Instruction picks the register placed between data input and output.
  always @* begin
    dr_len = `LEN_BYPASS;
    dr_cap = {`DR_MAX{1'b0}};
    case (ir_q)
      `IR_IDCODE: begin
        dr_len = `LEN_ID;
        dr_cap = {91'd0, `IDCODE_VALUE};
      end
      `IR_USER_SIGNATURE_READ, `IR_USER_SIGNATURE_PROG: begin
        dr_len = `LEN_ID;
        dr_cap = {91'd0, user_signature_q};
      end
      `IR_PLD_ADDR: begin
        dr_len = `LEN_PLD_ADDR;
        dr_cap = {14'd0, pld_addr_q};
      end
      `IR_PLD_DATA: begin
        dr_len = `LEN_PLD_DATA;
        dr_cap = fuse_q ? {`DR_MAX{1'b0}} : pld_nv_q;
      end
      `IR_CFG_ADDR: begin
        dr_len = `LEN_CFG_ADDR;
        dr_cap = {111'd0, cfg_addr_q};
      end
      `IR_CFG_SHIFT, `IR_CFG_VERIFY: begin
        dr_len = `LEN_CFG_DATA;
        dr_cap = fuse_q ? {`DR_MAX{1'b0}} : {67'd0, cfg_row};
      end
      `IR_SAMPLE: begin
        dr_len = `LEN_BSR;
        dr_cap = {119'd0, func_in};
      end
      default: begin
        dr_len = `LEN_BYPASS;
        dr_cap = {`DR_MAX{1'b0}};
      end
    endcase
  end
  // ----------------------------------------
  // Rising test clock actions
  // ----------------------------------------
  wire to_idle = (st == `ST_UPIR) && !tms_s;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_q       <= `IR_IDCODE;
      ir_sh_q    <= `IR_IDCODE;
      dr_q       <= {`DR_MAX{1'b0}};
      id_cnt_q   <= 3'd0;
      alt_lock_q <= 1'b0;
      pld_addr_q <= 109'd0;
      pld_data_q <= 123'd0;
      pld_nv_q   <= {123{`ERASED_BIT}};
      cfg_addr_q <= 12'd0;
      cfg_data_q <= 56'd0;
      user_signature_q <= `USER_SIGNATURE_RESET;
      fuse_q     <= 1'b0;
      prog_en_q  <= 1'b0;
      for (k = 0; k < `CFG_ROWS; k = k + 1) begin
        cfg_nv_q[k] <= {56{`ERASED_BIT}};
      end
    end else if (tck_rise) begin
      case (st)
        `ST_TLR: begin
          ir_q       <= `IR_IDCODE;
          id_cnt_q   <= 3'd0;
          alt_lock_q <= 1'b0;
          prog_en_q  <= 1'b0;
        end
        `ST_CAPIR: begin
          ir_sh_q <= `IR_IDCODE;
          ir_q    <= `IR_IDCODE;
        end
        `ST_SHIR: begin
          ir_sh_q <= {din, ir_sh_q[`IR_LEN-1:1]};
        end
        `ST_UPIR: begin
          ir_q <= ir_sh_q;
          // Expected ID code is 0001 0110 shifted in by the controller.
          if (ir_sh_q == `IR_IDCODE) begin
            if (id_cnt_q == `IDLOAD_COUNT - 3'd1) begin
              alt_lock_q <= 1'b1;
            end
            if (id_cnt_q != `IDLOAD_COUNT) begin
              id_cnt_q <= id_cnt_q + 3'd1;
            end
          end else begin
            id_cnt_q <= 3'd0;
          end
          if (ir_sh_q == `IR_PROG_EN) begin
            prog_en_q <= 1'b1;
          end
          if (ir_sh_q == `IR_PROG_DIS) begin
            prog_en_q <= 1'b0;
          end
          // Non-volatile operations start on the entry into Run-Test/Idle.
          if (to_idle && prog_en_q) begin
            case (ir_sh_q)
              `IR_PLD_PROG: pld_nv_q <= pld_data_q;
              `IR_CFG_PROG: cfg_nv_q[cfg_addr_q[1:0]] <= cfg_data_q;
              `IR_PROG_SEC: fuse_q <= 1'b1;
              `IR_CFG_ERASE: begin
                for (k = 0; k < `CFG_ROWS; k = k + 1) begin
                  cfg_nv_q[k] <= {56{`ERASED_BIT}};
                end
              end
              `IR_BULK_ERASE: begin
                fuse_q   <= 1'b0;
                pld_nv_q <= {123{`ERASED_BIT}};
                user_signature_q <= {32{`ERASED_BIT}};
                for (k = 0; k < `CFG_ROWS; k = k + 1) begin
                  cfg_nv_q[k] <= {56{`ERASED_BIT}};
                end
              end
              default: fuse_q <= fuse_q;
            endcase
          end
        end
        `ST_CAPDR: begin
          dr_q <= dr_cap;
        end
        `ST_SHDR: begin
          dr_q <= dr_shift;
        end
        `ST_UPDR: begin
          case (ir_q)
            `IR_PLD_ADDR:  pld_addr_q <= dr_q[108:0];
            `IR_PLD_DATA:  pld_data_q <= dr_q;
            `IR_CFG_ADDR:  cfg_addr_q <= dr_q[11:0];
            `IR_CFG_SHIFT: cfg_data_q <= dr_q[55:0];
            `IR_USER_SIGNATURE_PROG: begin
              if (prog_en_q) begin
                user_signature_q <= dr_q[31:0];
              end
            end
            default: pld_addr_q <= pld_addr_q;
          endcase
        end
        default: ir_q <= ir_q;
      endcase
    end
  end
  // ----------------------------------------
  // Falling test clock output
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_q <= (st == `ST_SHIR) || (st == `ST_SHDR);
      tdo_q    <= (st == `ST_SHIR) ? ir_sh_q[0] : dr_q[0];
    end
  end
  assign test_data_out    = tdo_q;
  assign test_data_out_oe = tdo_oe_q;
  // ----------------------------------------
  // Pin control
  // ----------------------------------------
  reg [`N_PINS-1:0]  pin_out_q;
  reg [`N_PINS-1:0]  pin_oe_q;
  reg [`N_GATES-1:0] gate_q;
  reg [`N_INS-1:0]   in_q;
  wire               outs_off = prog_only || (ir_q == `IR_HIGHZ);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_out_q <= {`N_PINS{1'b0}};
      pin_oe_q  <= {`N_PINS{1'b0}};
      gate_q    <= {`N_GATES{1'b0}};
      in_q      <= {`N_INS{1'b0}};
    end else begin
      pin_out_q <= func_out;
      pin_oe_q  <= outs_off ? {`N_PINS{1'b0}} : func_out_oe;
      gate_q    <= outs_off ? {`N_GATES{1'b0}} : gate_drive_req;
      in_q      <= prog_only ? {`N_INS{1'b0}} : func_in;
    end
  end
  assign pin_out            = pin_out_q;
  assign pin_oe             = pin_oe_q;
  assign gate_driver_output = gate_q;
  assign func_in_gated      = in_q;
  assign security_fuse      = fuse_q;
endmodule

// ### jtag_port_alt_data_input_asserts.sv
// Concurrent checks on the pins of the test port.
`timescale 1ns/1ps
`include "jtag_port_defines.vh"
module jtag_port_alt_data_input_asserts (
  input wire                 ref_clk,                // System clock.
  input wire                 rst,                    // Asynchronous reset.
  input wire                 test_clk,               // Test clock pin.
  input wire                 data_input_select_pin,  // Data input select.
  input wire                 programming_supply_pin, // Programming supply only.
  input wire [`N_PINS-1:0]   func_out,               // Core output values.
  input wire                 test_data_out,          // Test data output.
  input wire                 test_data_out_oe,       // Test data output enable.
  input wire                 select_pullup_en,       // Select pad pull-up.
  input wire [`N_PINS-1:0]   pin_out,                // Output pin values.
  input wire [`N_PINS-1:0]   pin_oe,                 // Output pin enables.
  input wire [`N_GATES-1:0]  gate_driver_output,     // Gate-driver outputs.
  input wire [`N_INS-1:0]    func_in_gated,          // Gated inputs.
  input wire                 alt_input_active        // Alternate input in use.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_pullup_on: assert property (select_pullup_en == 1'b1)
    else $error("select pull-up not enabled");
  chk_sel_low_alt: assert property ((!data_input_select_pin)[*4] |-> alt_input_active)
    else $error("select low but alternate input not used");
  chk_reset_normal: assert property ($past(rst) && data_input_select_pin |-> !alt_input_active)
    else $error("alternate input active after reset");
  chk_prog_oe_off: assert property (programming_supply_pin[*4] |-> pin_oe == '0)
    else $error("outputs enabled on programming supply");
  chk_prog_gate_low: assert property (programming_supply_pin[*4] |->
    gate_driver_output == '0 && func_in_gated == '0)
    else $error("gate driver or inputs live on programming supply");
  chk_pin_follow: assert property (1'b1 |=> pin_out == $past(func_out))
    else $error("output pins do not follow core values");
  chk_tdo_fall: assert property ($changed(test_data_out) |-> $past(test_clk, 2) == 1'b0)
    else $error("data output changed after a rising test clock");
  chk_oe_fall: assert property ($changed(test_data_out_oe) |-> $past(test_clk, 2) == 1'b0)
    else $error("output enable changed after a rising test clock");
endmodule

// ### jtag_ctrl_model.sv
// Behavioural test controller driving the serial pins of the port.
`timescale 1ns/1ps
module jtag_ctrl_model (
  input  wire ref_clk, // System clock, paces the test clock.
  input  wire tdo,              // Data from the port.
  input  wire tdo_oe,           // Port drives the data line while high.
  output reg  tck,              // Test clock, still low between frames.
  output reg  tms,              // Mode select.
  output reg  tdi,              // Normal data line.
  output reg  alternate_data_in // Alternate data line.
);
  reg use_alt = 1'b0; // Data on the alternate line, its inverse on the other.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    alternate_data_in = 1'b1;
  end
  // One test clock period of 200 ns; tdo is taken before the fall.
  task bit_step(input m, input b, output q);
    begin
      @(negedge ref_clk);
      tms = m;
      tdi = use_alt ? ~b : b;
      alternate_data_in = use_alt ? b : ~b;
      @(negedge ref_clk);
      tck = 1'b1;
      repeat (4) @(negedge ref_clk);
      // A released data line reads as the inverse, so a missing enable corrupts the data.
      q = tdo_oe ? tdo : ~tdo;
      tck = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  // From Run-Test/Idle through one shift back to Run-Test/Idle, LSB first.
  task scan(input ir, input integer n, input [159:0] din, output [159:0] dout);
    integer i;
    reg     q;
    begin
      dout = 160'h0;
      bit_step(1'b1, 1'b0, q);
      if (ir) bit_step(1'b1, 1'b0, q);
      bit_step(1'b0, 1'b0, q);
      bit_step(1'b0, 1'b0, q);
      for (i = 0; i < n; i = i + 1) begin
        bit_step(i == n - 1, din[i], q);
        dout[i] = q;
      end
      bit_step(1'b1, 1'b0, q);
      bit_step(1'b0, 1'b0, q);
      tdi = ~tdi;
      alternate_data_in = ~alternate_data_in;
    end
  endtask
  task tlr;
    reg q;
    begin
      repeat (5) bit_step(1'b1, 1'b0, q);
      bit_step(1'b0, 1'b0, q);
    end
  endtask
endmodule

// ### jtag_port_alt_data_input_tb.sv
// Self-checking bench for the test port with alternate data input.
`timescale 1ns/1ps
`include "jtag_port_defines.vh"
module jtag_port_alt_data_input_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  reg                  ref_clk = 1'b0;
  reg                  rst = 1'b1;
  reg                  data_input_select_pin = 1'b1;
  reg                  programming_supply_pin = 1'b0;
  reg  [`N_PINS-1:0]   func_out = 14'h0;
  reg  [`N_PINS-1:0]   func_out_oe = 14'h0;
  reg  [`N_GATES-1:0]  gate_drive_req = 2'h0;
  reg  [`N_INS-1:0]    func_in = 4'h0;
  wire                 test_clk, test_mode_sel, test_data_in, alternate_data_in;
  wire                 test_data_out, test_data_out_oe, select_pullup_en, alt_input_active, security_fuse;
  wire [`N_PINS-1:0]   pin_out, pin_oe;
  wire [`N_GATES-1:0]  gate_driver_output;
  wire [`N_INS-1:0]    func_in_gated;
  integer              n_mismatch = 0;
  integer              checks_done = 0;
  integer              cycles = 0;
  integer              seed = 32'hfa520c0d;
  integer              k;
  reg  [159:0]         d, r;
  localparam [71:0] CODES = {8'hff, 8'h1c, 8'h2b, 8'h16, 8'h1a, 8'h2d, 8'h01, 8'h02, 8'h00};
  localparam [71:0] LENS  = {8'h01, 8'h04, 8'h0c, 8'h20, 8'h20, 8'h38, 8'h6d, 8'h7b, 8'h01};
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    {func_in, func_out, func_out_oe} <= $random(seed);
    gate_drive_req <= gate_drive_req + 2'h1;
  end
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  jtag_port_alt_data_input uut (
    .ref_clk(ref_clk), .rst(rst), .test_clk(test_clk), .test_mode_sel(test_mode_sel),
    .test_data_in(test_data_in), .alternate_data_in(alternate_data_in),
    .data_input_select_pin(data_input_select_pin), .programming_supply_pin(programming_supply_pin),
    .func_out(func_out), .func_out_oe(func_out_oe), .gate_drive_req(gate_drive_req), .func_in(func_in),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe), .select_pullup_en(select_pullup_en),
    .pin_out(pin_out), .pin_oe(pin_oe), .gate_driver_output(gate_driver_output),
    .func_in_gated(func_in_gated), .alt_input_active(alt_input_active), .security_fuse(security_fuse));
  jtag_ctrl_model m (.ref_clk(ref_clk), .tdo(test_data_out), .tdo_oe(test_data_out_oe), .tck(test_clk),
    .tms(test_mode_sel), .tdi(test_data_in), .alternate_data_in(alternate_data_in));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [8:0] bypass_out(input [7:0] v);
    bypass_out = {v, 1'b0};
  endfunction
  task check(input [63:0] seen, input [63:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task ir(input [7:0] c);
    m.scan(1'b1, 8, {152'h0, c}, d);
  endtask
  task user_signature_check(input [31:0] exp);
    begin
      ir(`IR_USER_SIGNATURE_READ);
      m.scan(1'b0, 32, 160'h0, d);
      check(d[31:0], exp);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    m.tlr;
    m.scan(1'b0, 32, 160'h0, d);
    check(d[31:0], `IDCODE_VALUE);
    m.scan(1'b1, 8, 160'hff, d);
    check(d[7:0], `IR_IDCODE);
    for (k = 0; k < 9; k = k + 1) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      ir(CODES[k*8 +: 8]);
      m.scan(1'b0, LENS[k*8 +: 8] + 8, r, d);
      check(d[LENS[k*8 +: 8] +: 8], r[7:0]);
    end
    m.scan(1'b0, 9, r, d);
    check(d[8:0], bypass_out(r[7:0]));
    $display("test lengths done");
    for (k = 0; k < 3; k = k + 1) ir(`IR_IDCODE);
    m.tlr;
    ir(`IR_IDCODE);
    ir(`IR_BYPASS);
    for (k = 0; k < 3; k = k + 1) ir(`IR_IDCODE);
    check(alt_input_active, 1'b0);
    ir(`IR_IDCODE);
    check(alt_input_active, 1'b1);
    m.use_alt = 1'b1;
    user_signature_check(`USER_SIGNATURE_RESET);
    m.tlr;
    m.use_alt = 1'b0;
    check(alt_input_active, 1'b0);
    $display("test id loads done");
    data_input_select_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(alt_input_active, 1'b1);
    m.use_alt = 1'b1;
    user_signature_check(`USER_SIGNATURE_RESET);
    data_input_select_pin = 1'b1;
    m.use_alt = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(alt_input_active, 1'b0);
    $display("test select pin done");
    m.tlr;
    ir(`IR_PROG_SEC);
    check(security_fuse, 1'b0);
    ir(`IR_PROG_EN);
    ir(`IR_USER_SIGNATURE_PROG);
    m.scan(1'b0, 32, r, d);
    user_signature_check(r[31:0]);
    ir(`IR_CFG_ADDR);
    m.scan(1'b0, 12, 160'h0, d);
    ir(`IR_CFG_SHIFT);
    m.scan(1'b0, 56, r, d);
    ir(`IR_CFG_PROG);
    ir(`IR_CFG_SHIFT);
    m.scan(1'b0, 56, 160'h0, d);
    check(d[55:0], r[55:0]);
    ir(`IR_PROG_SEC);
    check(security_fuse, 1'b1);
    ir(`IR_PLD_DATA);
    m.scan(1'b0, 123, 160'h0, d);
    check(d[63:0], 64'h0);
    ir(`IR_PROG_DIS);
    m.tlr;
    check(security_fuse, 1'b1);
    ir(`IR_PROG_EN);
    ir(`IR_BULK_ERASE);
    check(security_fuse, 1'b0);
    ir(`IR_CFG_SHIFT);
    m.scan(1'b0, 56, 160'h0, d);
    check(d[55:0], {56{`ERASED_BIT}});
    user_signature_check(`USER_SIGNATURE_RESET);
    $display("test programming done");
    programming_supply_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    check({pin_oe, gate_driver_output, func_in_gated}, 20'h0);
    programming_supply_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    check({pin_oe, gate_driver_output, func_in_gated}, {func_out_oe, gate_drive_req, func_in});
    ir(`IR_HIGHZ);
    check({pin_oe, gate_driver_output, func_in_gated}, {16'h0, func_in});
    m.tlr;
    check({pin_oe, gate_driver_output}, {func_out_oe, gate_drive_req});
    $display("test supply done");
    stop_test;
  end
endmodule
bind jtag_port_alt_data_input jtag_port_alt_data_input_asserts chk (
  .ref_clk(ref_clk), .rst(rst), .test_clk(test_clk), .data_input_select_pin(data_input_select_pin),
  .programming_supply_pin(programming_supply_pin), .func_out(func_out), .test_data_out(test_data_out),
  .test_data_out_oe(test_data_out_oe), .select_pullup_en(select_pullup_en), .pin_out(pin_out),
  .pin_oe(pin_oe), .gate_driver_output(gate_driver_output), .func_in_gated(func_in_gated),
  .alt_input_active(alt_input_active));
